// *** rtl/link_regs_pkg.sv ***
// constants and carrier types for the debug link control and status register bank
package link_regs_pkg;

  // ----------------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------------
  localparam logic [3:0] OFF_REVISION   = 4'h0;
  localparam logic [3:0] OFF_ERROR      = 4'h1;
  localparam logic [3:0] OFF_FRAMING    = 4'h2;
  localparam logic [3:0] OFF_FEATURE    = 4'h3;
  localparam logic [3:0] OFF_KEYS       = 4'h7;
  localparam logic [3:0] OFF_RESET_REQ  = 4'h8;
  localparam logic [3:0] OFF_CLOCK_SEL  = 4'h9;
  localparam logic [3:0] OFF_SYS_ACCESS = 4'ha;
  localparam logic [3:0] OFF_SYS_STATE  = 4'hb;
  localparam logic [3:0] OFF_CHECK      = 4'hc;

  // ----------------------------------------------------------------------
  // field positions and masks
  // ----------------------------------------------------------------------
  localparam int          BIT_GAP_EN       = 7;
  localparam int          BIT_PARITY_IGN   = 5;
  localparam int          BIT_TIMEOUT_OFF  = 4;
  localparam int          BIT_RESP_SIG_OFF = 3;
  localparam int          BIT_NACK_OFF     = 4;
  localparam int          BIT_CONT_OFF     = 3;
  localparam int          BIT_LINK_DIS     = 2;
  localparam int          BIT_UROW_KEY     = 5;
  localparam int          BIT_NVM_KEY      = 4;
  localparam int          BIT_ERASE_KEY    = 3;
  localparam int          BIT_UROW_DONE    = 1;
  localparam int          BIT_CLK_HOLD     = 0;
  localparam logic [7:0]  FRAMING_MASK     = 8'hbf;
  localparam logic [7:0]  FEATURE_MASK     = 8'h1c;

  // ----------------------------------------------------------------------
  // codes and reset values
  // ----------------------------------------------------------------------
  localparam logic [2:0]  ERR_NONE         = 3'h0;
  localparam logic [2:0]  ERR_PARITY       = 3'h1;
  localparam logic [2:0]  ERR_FRAME        = 3'h2;
  localparam logic [2:0]  ERR_TIMEOUT      = 3'h3;
  localparam logic [2:0]  ERR_CLOCK_REC    = 3'h4;
  localparam logic [2:0]  ERR_BUS          = 3'h6;
  localparam logic [2:0]  ERR_CONTENTION   = 3'h7;
  localparam logic [7:0]  RESET_ASSERT     = 8'h59;
  localparam logic [7:0]  RESET_RELEASE    = 8'h00;
  localparam logic [2:0]  GUARD_RESERVED   = 3'h7;
  localparam logic [7:0]  GUARD_MAX_CYCLES = 8'h80;
  localparam logic [1:0]  CLKSEL_RESERVED  = 2'h0;
  localparam logic [1:0]  CLKSEL_DEFAULT   = 2'h3;
  localparam int          TIMEOUT_CYCLES   = 65536;

  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic parity;
    logic frame;
    logic clock_recovery;
    logic bus;
  } link_err_events_t;

  typedef struct packed {
    logic       inter_byte_gap_enable;
    logic       response_signature_off;
    logic [1:0] link_clock_divider;
    logic       contention_detect_off;
  } link_cfg_t;

  typedef struct packed {
    logic       device_locked;
    logic       system_asleep;
    logic       nvm_program_active;
    logic       user_row_program_ready;
    logic [2:0] check_result;
  } sys_state_t;

endpackage

// *** rtl/debug_link_control_regs.sv ***
// control and status register bank of the single-wire debug link
// Function
// RULE1: registers reachable only through link instructions
// RULE2: error signature loads on error, clears on read
// RULE3: error codes one to seven, five reserved
// RULE4: gap enable inserts two idle bits
// RULE5: parity ignore suppresses parity errors
// RULE6: timeout after 65536 cycles unless disabled
// RULE7: response signature off suppresses signatures
// RULE8: guard time 128 halving to 2 cycles
// RULE9: nack on reset during load/store
// RULE10: contention detect while control bit clear
// RULE11: link disable resets link, drops clock request; code drops it one cycle, then clock hold resets to 1 and re-requests
// RULE12: user row key set; tool write closes
// RULE13: nvm key set; cleared when programming starts
// RULE14: erase key cleared by reset request
// RULE15: 0x59 asserts system reset, 0x00 releases
// RULE16: system reset leaves link logic running
// RULE17: revision read-only in bits 7:4
// RULE18: clock select 16/8/4 MHz, default 4
// RULE19: lock bit reflects device lock state
// RULE20: check result field is one-hot
// RULE21: clock hold keeps system clock requested
// RULE22: reserved bits and offsets read zero
// RULE23: control registers read back as written
`timescale 1ns/1ps

module debug_link_control_regs
  import link_regs_pkg::*;
#(
  parameter logic [3:0] REVISION     = 4'h1, // arbitrary value
  parameter int         TIMEOUT_LIM  = TIMEOUT_CYCLES
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  // register port from the link instruction decoder only
  input  wire logic [3:0]       reg_addr, // RULE1
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic [7:0]            reg_rdata,
  // physical layer events and status
  input  wire link_err_events_t err_events,
  input  wire logic             access_wait,
  input  wire logic             turnaround_req,
  input  wire logic             tx_drive,
  input  wire logic             tx_level,
  input  wire logic             link_pin_in,
  input  wire logic             ldst_busy,
  input  wire logic             sys_reset_in,
  // key decoder and system side
  input  wire logic             erase_key_decoded,
  input  wire logic             nvm_key_decoded,
  input  wire logic             urow_key_decoded,
  input  wire logic             nvm_prog_started,
  input  wire sys_state_t       sys_state,
  output link_cfg_t             link_cfg,
  output logic                  tx_go,
  output logic                  nack_send,
  output logic                  link_reset,
  output logic                  sys_reset_req,
  output logic                  sys_clock_req,
  output logic                  user_row_commit
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [2:0]  error_signature_reg;
  logic [7:0]  framing_reg;
  logic [7:0]  feature_reg;
  logic [2:0]  keys_reg;
  logic [7:0]  reset_req_reg;
  logic [1:0]  clock_sel_reg;
  logic        clock_hold_reg;
  logic        sys_reset_seen_reg;
  logic [16:0] timeout_cnt_reg;
  logic        timeout_flag_reg;
  logic [7:0]  guard_cnt_reg;
  logic [2:0]  pin_sync_reg;
  logic        pin_level_reg;
  // three sync flops plus the level flop sit between pin and compare
  localparam int PIN_LAG = 4;
  logic [PIN_LAG-1:0] drive_hist_reg;
  logic [PIN_LAG-1:0] level_hist_reg;
  logic        reset_prev_reg;
  logic [7:0]  reg_rdata_reg;
  logic        tx_go_reg;
  logic        nack_reg;
  logic        link_reset_reg;
  logic        sys_clock_req_reg;
  logic        commit_reg;
  logic        sys_reset_req_reg;

  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  wire         wr_framing   = reg_wr && reg_addr == OFF_FRAMING;
  wire         wr_feature   = reg_wr && reg_addr == OFF_FEATURE;
  wire         wr_keys      = reg_wr && reg_addr == OFF_KEYS;
  wire         wr_reset_req = reg_wr && reg_addr == OFF_RESET_REQ;
  wire         wr_clock_sel = reg_wr && reg_addr == OFF_CLOCK_SEL;
  wire         wr_sys_acc   = reg_wr && reg_addr == OFF_SYS_ACCESS;
  wire         rd_error     = reg_rd && reg_addr == OFF_ERROR;
  wire         rd_sys_state = reg_rd && reg_addr == OFF_SYS_STATE;
  // disable acts on the write itself; the bit is never held set
  wire         disable_wr   = wr_feature && reg_wdata[BIT_LINK_DIS]; // RULE11

  wire         parity_ign   = framing_reg[BIT_PARITY_IGN];
  wire         timeout_off  = framing_reg[BIT_TIMEOUT_OFF];
  wire [2:0]   guard_sel    = framing_reg[2:0];
  wire         nack_off     = feature_reg[BIT_NACK_OFF];
  wire         cont_off     = feature_reg[BIT_CONT_OFF];

  // change counts only once the second and third flops agree
  wire         pin_stable   = pin_sync_reg[1] == pin_sync_reg[2];
  wire         contention   = !cont_off && drive_hist_reg[PIN_LAG-1] && pin_stable &&
                              pin_level_reg != level_hist_reg[PIN_LAG-1]; // RULE10

  wire         timeout_hit  = !timeout_off && access_wait && !timeout_flag_reg &&
                              timeout_cnt_reg == 17'(TIMEOUT_LIM - 1); // RULE6

  // highest code wins when several errors land together
  logic [2:0] err_code;
  always_comb begin
    err_code = ERR_NONE; // RULE3
    if (contention)
      err_code = ERR_CONTENTION;
    else if (err_events.bus)
      err_code = ERR_BUS;
    else if (err_events.clock_recovery)
      err_code = ERR_CLOCK_REC;
    else if (timeout_hit)
      err_code = ERR_TIMEOUT;
    else if (err_events.frame)
      err_code = ERR_FRAME;
    else if (err_events.parity && !parity_ign) // RULE5
      err_code = ERR_PARITY;
  end

  // guard count: 128 shifted down by the select code, reserved code keeps max
  wire [7:0]  guard_len  = (guard_sel == GUARD_RESERVED) ? GUARD_MAX_CYCLES :
                           (GUARD_MAX_CYCLES >> guard_sel); // RULE8

  wire        sys_reset_on  = reset_req_reg == RESET_ASSERT;
  wire        reset_rise    = (sys_reset_on || sys_reset_in) && !reset_prev_reg;

  wire [7:0]  sys_state_rd = {2'h0, sys_reset_seen_reg, sys_state.system_asleep,
                              sys_state.nvm_program_active,
                              sys_state.user_row_program_ready, 1'b0,
                              sys_state.device_locked}; // RULE19

  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00; // RULE22
    case (reg_addr)
      OFF_REVISION:   rd_mux = {REVISION, 4'h0}; // RULE17
      OFF_ERROR:      rd_mux = {5'h00, error_signature_reg};
      OFF_FRAMING:    rd_mux = framing_reg; // RULE23
      OFF_FEATURE:    rd_mux = feature_reg;
      OFF_KEYS:       rd_mux = {2'h0, keys_reg, 3'h0};
      OFF_RESET_REQ:  rd_mux = reset_req_reg;
      OFF_CLOCK_SEL:  rd_mux = {6'h00, clock_sel_reg};
      OFF_SYS_ACCESS: rd_mux = {7'h00, clock_hold_reg};
      OFF_SYS_STATE:  rd_mux = sys_state_rd;
      OFF_CHECK:      rd_mux = {5'h00, sys_state.check_result}; // RULE20
      default:        rd_mux = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------------
  // error signature and timeout
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst || disable_wr)
      error_signature_reg <= ERR_NONE;
    else if (err_code != ERR_NONE)
      error_signature_reg <= err_code; // RULE2
    else if (rd_error)
      error_signature_reg <= ERR_NONE; // RULE2
  end

  always_ff @(posedge core_clk) begin
    if (rst || disable_wr || !access_wait) begin
      timeout_cnt_reg  <= 17'h00000;
      timeout_flag_reg <= 1'b0;
    end else if (timeout_hit) begin
      timeout_flag_reg <= 1'b1;
    end else if (!timeout_flag_reg) begin
      timeout_cnt_reg  <= timeout_cnt_reg + 17'h00001;
    end
  end

  // ----------------------------------------------------------------------
  // control registers; a disable write clears the whole link setup
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst || disable_wr) begin // RULE11
      framing_reg    <= 8'h00;
      feature_reg    <= 8'h00;
      clock_sel_reg  <= CLKSEL_DEFAULT; // RULE18
      clock_hold_reg <= 1'b1; // RULE21
    end else begin
      if (wr_framing)
        framing_reg <= reg_wdata & FRAMING_MASK; // RULE23
      if (wr_feature)
        feature_reg <= reg_wdata & FEATURE_MASK;
      if (wr_clock_sel && reg_wdata[1:0] != CLKSEL_RESERVED)
        clock_sel_reg <= reg_wdata[1:0]; // RULE18
      if (wr_sys_acc)
        clock_hold_reg <= reg_wdata[BIT_CLK_HOLD]; // RULE21
    end
  end

  // ----------------------------------------------------------------------
  // key flags; decode sets win over key clears in the same cycle, a disable write wins over both
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst || disable_wr) begin
      keys_reg <= 3'h0;
    end else begin
      keys_reg[2] <= urow_key_decoded ||
                     (keys_reg[2] && !(wr_keys && reg_wdata[BIT_UROW_KEY])); // RULE12
      keys_reg[1] <= nvm_key_decoded ||
                     (keys_reg[1] && !nvm_prog_started); // RULE13
      keys_reg[0] <= erase_key_decoded ||
                     (keys_reg[0] && !(wr_reset_req && reg_wdata == RESET_ASSERT)); // RULE14
    end
  end

  // ----------------------------------------------------------------------
  // system reset request; only rst and disable touch the link state
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst || disable_wr)
      reset_req_reg <= RESET_RELEASE;
    else if (wr_reset_req && (reg_wdata == RESET_ASSERT || reg_wdata == RESET_RELEASE))
      reset_req_reg <= reg_wdata; // RULE15
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      reset_prev_reg     <= 1'b0;
      sys_reset_seen_reg <= 1'b0;
    end else begin
      reset_prev_reg     <= sys_reset_on || sys_reset_in; // RULE16
      sys_reset_seen_reg <= sys_reset_on || sys_reset_in ||
                            (sys_reset_seen_reg && !rd_sys_state);
    end
  end

  // ----------------------------------------------------------------------
  // turnaround guard and pin synchroniser
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst || disable_wr)
      guard_cnt_reg <= 8'h00;
    else if (turnaround_req)
      guard_cnt_reg <= guard_len; // RULE8
    else if (guard_cnt_reg != 8'h00)
      guard_cnt_reg <= guard_cnt_reg - 8'h01;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin_sync_reg  <= 3'h7;
      pin_level_reg <= 1'b1;
    end else begin
      pin_sync_reg  <= {pin_sync_reg[1:0], link_pin_in};
      if (pin_stable)
        pin_level_reg <= pin_sync_reg[2];
    end
  end

  // the pin answer lags the drive by the synchroniser, so compare against
  // the drive as it was then; a live compare flags every level change
  always_ff @(posedge core_clk) begin
    if (rst) begin
      drive_hist_reg <= '0;
      level_hist_reg <= '1;
    end else begin
      drive_hist_reg <= {drive_hist_reg[PIN_LAG-2:0], tx_drive};
      level_hist_reg <= {level_hist_reg[PIN_LAG-2:0], tx_level};
    end
  end

  // ----------------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      reg_rdata_reg     <= 8'h00;
      tx_go_reg         <= 1'b0;
      nack_reg          <= 1'b0;
      link_reset_reg    <= 1'b0;
      sys_clock_req_reg <= 1'b0;
      commit_reg        <= 1'b0;
      sys_reset_req_reg <= 1'b0;
    end else begin
      reg_rdata_reg     <= reg_rd ? rd_mux : 8'h00;
      tx_go_reg         <= guard_cnt_reg == 8'h01; // RULE8
      // nack is a response signature, so it obeys the signature switch too
      nack_reg          <= reset_rise && ldst_busy && !nack_off &&
                           !framing_reg[BIT_RESP_SIG_OFF]; // RULE9 RULE7
      link_reset_reg    <= disable_wr; // RULE11
      sys_clock_req_reg <= clock_hold_reg && !disable_wr; // RULE21 RULE11
      // commit only allowed once the user row key is in
      commit_reg        <= wr_sys_acc && reg_wdata[BIT_UROW_DONE] && keys_reg[2];
      sys_reset_req_reg <= sys_reset_on; // RULE15
    end
  end

  assign reg_rdata       = reg_rdata_reg;
  assign tx_go           = tx_go_reg;
  assign nack_send       = nack_reg;
  assign link_reset      = link_reset_reg;
  assign sys_clock_req   = sys_clock_req_reg;
  assign user_row_commit = commit_reg;
  assign sys_reset_req   = sys_reset_req_reg;
  // straight flop fields; the link applies them on its next transfer
  assign link_cfg = '{inter_byte_gap_enable:  framing_reg[BIT_GAP_EN], // RULE4
                      response_signature_off: framing_reg[BIT_RESP_SIG_OFF], // RULE7
                      link_clock_divider:     clock_sel_reg,
                      contention_detect_off:  cont_off};

endmodule

// *** testbench/link_regs_monitor.sv ***
// concurrent checks on the debug link register bank ports
`timescale 1ns/1ps
module link_regs_monitor
  import link_regs_pkg::*;
#(
  parameter logic [3:0] REVISION = 4'h1
) (
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire link_cfg_t  link_cfg,
  input wire logic       link_reset,
  input wire logic       sys_reset_req,
  input wire logic       nack_send,
  input wire logic       tx_go
);
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  wire wr_fr = reg_wr && reg_addr == OFF_FRAMING;
  wire wr_fb = reg_wr && reg_addr == OFF_FEATURE;
  wire wr_cs = reg_wr && reg_addr == OFF_CLOCK_SEL;
  wire wr_rq = reg_wr && reg_addr == OFF_RESET_REQ;
  // cfg is back at its reset shape once the pulse has gone
  sequence dis_seq;
    link_reset ##1 (!link_reset && link_cfg == 5'h06);
  endsequence
  AST_IDLE_RDATA: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero without a read");
  AST_REV_RO: assert property (reg_rd && reg_addr == OFF_REVISION |=>
    reg_rdata == {REVISION, 4'h0}) else $error("revision read wrong");
  AST_GAP_CFG: assert property (wr_fr |=>
    link_cfg.inter_byte_gap_enable == $past(reg_wdata[BIT_GAP_EN]))
    else $error("gap enable not applied");
  AST_RSIG_CFG: assert property (wr_fr |=>
    link_cfg.response_signature_off == $past(reg_wdata[BIT_RESP_SIG_OFF]))
    else $error("response signature setting not applied");
  AST_CONT_CFG: assert property (wr_fb && !reg_wdata[BIT_LINK_DIS] |=>
    link_cfg.contention_detect_off == $past(reg_wdata[BIT_CONT_OFF]))
    else $error("contention setting not applied");
  AST_DIV_CFG: assert property (wr_cs && reg_wdata[1:0] != CLKSEL_RESERVED |=>
    link_cfg.link_clock_divider == $past(reg_wdata[1:0])) else $error("divider not applied");
  AST_DIV_KEEP: assert property (wr_cs && reg_wdata[1:0] == CLKSEL_RESERVED |=>
    $stable(link_cfg.link_clock_divider)) else $error("reserved divider accepted");
  AST_RST_ASSERT: assert property (wr_rq && reg_wdata == RESET_ASSERT |->
    ##[1:2] sys_reset_req) else $error("system reset not asserted");
  AST_RST_FREE: assert property (wr_rq && reg_wdata == RESET_RELEASE |->
    ##[1:2] !sys_reset_req) else $error("system reset not released");
  AST_DISABLE: assert property (wr_fb && reg_wdata[BIT_LINK_DIS] |->
    ##[1:2] dis_seq) else $error("link disable sequence wrong");
  AST_NACK_PULSE: assert property (nack_send |=> !nack_send)
    else $error("nack longer than one cycle");
  AST_TXGO_PULSE: assert property (tx_go |=> !tx_go)
    else $error("tx go longer than one cycle");
endmodule

bind debug_link_control_regs link_regs_monitor #(.REVISION(REVISION)) mon (
  .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link_cfg(link_cfg),
  .link_reset(link_reset), .sys_reset_req(sys_reset_req), .nack_send(nack_send),
  .tx_go(tx_go));

// *** testbench/link_pin_model.sv ***
// behavioural far-side model of the single-wire link pin
`timescale 1ns/1ps
module link_pin_model (
  input  wire logic tx_drive,
  input  wire logic tx_level,
  input  wire logic clash,
  output logic      pin_level
);
  // ----------------------------------------------------------------
  // wire level
  // ----------------------------------------------------------------
  // released wire idles high on the pull-up; clash fights the device driver
  assign pin_level = tx_drive ? (tx_level ^ clash) : 1'b1;
endmodule

// *** testbench/tb_debug_link_control_regs.sv ***
// self-checking bench for the debug link register bank
`timescale 1ns/1ps
module tb_debug_link_control_regs;
  import link_regs_pkg::*;
  localparam int    TLIM = 16;
  logic             core_clk = 1'b0;
  logic             rst = 1'b1;
  logic [3:0]       reg_addr = 4'h0;
  logic [7:0]       reg_wdata = 8'h00;
  logic             reg_wr = 1'b0;
  logic             reg_rd = 1'b0;
  logic [7:0]       reg_rdata;
  link_err_events_t err_events = '0;
  logic             access_wait = 1'b0;
  logic             turn_req = 1'b0;
  logic             tx_drive = 1'b0;
  logic             clash = 1'b0;
  logic             tx_lvl = 1'b1;
  logic             pin_in;
  logic             ldst_busy = 1'b0;
  logic [3:0]       keys = 4'h0;
  sys_state_t       sys_state = '0;
  link_cfg_t        link_cfg;
  logic             tx_go, nack_send, link_reset, sys_reset_req, sys_clock_req, commit;
  int               failures = 0;
  int               tests_run = 0;
  int               cycles = 0;
  int               nacks = 0;
  int               commits = 0;
  int               resets = 0;
  int               n, k;
  logic [7:0]       rexp [16] = '{8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                                  8'h00, 8'h03, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0]       ecode [4] = '{8'h01, 8'h02, 8'h04, 8'h06};

  debug_link_control_regs #(.REVISION(4'h1), .TIMEOUT_LIM(TLIM)) dut (
    .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .err_events(err_events),
    .access_wait(access_wait), .turnaround_req(turn_req), .tx_drive(tx_drive),
    .tx_level(tx_lvl), .link_pin_in(pin_in), .ldst_busy(ldst_busy), .sys_reset_in(1'b0),
    .erase_key_decoded(keys[3]), .nvm_key_decoded(keys[2]), .urow_key_decoded(keys[1]),
    .nvm_prog_started(keys[0]), .sys_state(sys_state), .link_cfg(link_cfg),
    .tx_go(tx_go), .nack_send(nack_send), .link_reset(link_reset),
    .sys_reset_req(sys_reset_req), .sys_clock_req(sys_clock_req),
    .user_row_commit(commit));
  link_pin_model far (.tx_drive(tx_drive), .tx_level(tx_lvl), .clash(clash),
    .pin_level(pin_in));

  // ----------------------------------------------------------------
  // clock, pulse counters, hang limit
  // ----------------------------------------------------------------
  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    nacks <= nacks + int'(nack_send === 1'b1);
    commits <= commits + int'(commit === 1'b1);
    resets <= resets + int'(link_reset === 1'b1);
    if (cycles == 20000) begin
      failures++;
      finish_test();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  // bits: parity frame clockrec bus, erase nvm urow progstart, turnaround
  task automatic pulse(input logic [8:0] v);
    @(posedge core_clk);
    {err_events, keys, turn_req} <= v;
    @(posedge core_clk);
    {err_events, keys, turn_req} <= 9'h000;
  endtask
  task automatic idle(input int c);
    repeat (c) @(posedge core_clk);
  endtask
  task automatic finish_test();
    if (failures == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // sequence of tests
  // ----------------------------------------------------------------
  initial begin
    idle(2);
    rst <= 1'b0;
    for (n = 0; n < 16; n++) rd(n[3:0], rexp[n]);
    wr(OFF_FRAMING, 8'hff);
    rd(OFF_FRAMING, 8'hbf);
    chk({3'h0, link_cfg}, 8'h1e);
    wr(OFF_FEATURE, 8'hf8);
    rd(OFF_FEATURE, 8'h18);
    chk({3'h0, link_cfg}, 8'h1f);
    wr(OFF_REVISION, 8'hff);
    rd(OFF_REVISION, 8'h10);
    wr(4'h5, 8'hff);
    rd(4'h5, 8'h00);
    pulse(9'h100);
    rd(OFF_ERROR, 8'h00);
    access_wait <= 1'b1;
    idle(TLIM + 4);
    access_wait <= 1'b0;
    rd(OFF_ERROR, 8'h00);
    wr(OFF_FRAMING, 8'h00);
    for (n = 0; n < 4; n++) begin
      pulse(9'h100 >> n);
      rd(OFF_ERROR, ecode[n]);
      rd(OFF_ERROR, 8'h00);
    end
    pulse(9'h1e0);
    rd(OFF_ERROR, 8'h06);
    access_wait <= 1'b1;
    idle(TLIM + 3);
    access_wait <= 1'b0;
    rd(OFF_ERROR, ERR_TIMEOUT);
    for (n = 0; n < 3; n++) begin
      wr(OFF_FEATURE, 8'(n % 2 * 8));
      tx_drive <= 1'b1;
      tx_lvl <= n != 2;
      clash <= n != 2;
      idle(6);
      tx_drive <= 1'b0;
      clash <= 1'b0;
      tx_lvl <= 1'b1;
      idle(5);
      rd(OFF_ERROR, n == 0 ? 8'h07 : 8'h00);
    end
    for (n = 0; n < 8; n++) begin
      wr(OFF_FRAMING, 8'(n));
      pulse(9'h001);
      k = 0;
      while (tx_go !== 1'b1 && k < 300) begin
        @(posedge core_clk);
        #1 k++;
      end
      chk(8'(k), n == 7 ? 8'd128 : 8'(128 >> n));
    end
    pulse(9'h010);
    rd(OFF_KEYS, 8'h08);
    ldst_busy <= 1'b1;
    wr(OFF_RESET_REQ, RESET_ASSERT);
    idle(3);
    chk({7'h0, sys_reset_req}, 8'h01);
    chk(8'(nacks), 8'h01);
    rd(OFF_KEYS, 8'h00);
    rd(OFF_FRAMING, 8'h07);
    wr(OFF_RESET_REQ, 8'h12);
    rd(OFF_RESET_REQ, 8'h59);
    wr(OFF_RESET_REQ, RESET_RELEASE);
    idle(2);
    chk({7'h0, sys_reset_req}, 8'h00);
    wr(OFF_FEATURE, 8'h18);
    wr(OFF_RESET_REQ, RESET_ASSERT);
    wr(OFF_RESET_REQ, RESET_RELEASE);
    idle(2);
    chk(8'(nacks), 8'h01);
    ldst_busy <= 1'b0;
    sys_state <= 7'h6c;
    rd(OFF_SYS_STATE, 8'h35);
    rd(OFF_SYS_STATE, 8'h15);
    rd(OFF_CHECK, 8'h04);
    sys_state <= 7'h02;
    rd(OFF_SYS_STATE, 8'h00);
    rd(OFF_CHECK, 8'h02);
    pulse(9'h008);
    rd(OFF_KEYS, 8'h10);
    pulse(9'h002);
    rd(OFF_KEYS, 8'h00);
    pulse(9'h004);
    rd(OFF_KEYS, 8'h20);
    wr(OFF_SYS_ACCESS, 8'h03);
    idle(2);
    chk(8'(commits), 8'h01);
    rd(OFF_SYS_ACCESS, 8'h01);
    wr(OFF_KEYS, 8'h20);
    rd(OFF_KEYS, 8'h00);
    wr(OFF_SYS_ACCESS, 8'h00);
    idle(2);
    chk({7'h0, sys_clock_req}, 8'h00);
    wr(OFF_SYS_ACCESS, 8'h01);
    idle(2);
    chk({7'h0, sys_clock_req}, 8'h01);
    wr(OFF_CLOCK_SEL, 8'h01);
    rd(OFF_CLOCK_SEL, 8'h01);
    wr(OFF_CLOCK_SEL, 8'h00);
    rd(OFF_CLOCK_SEL, 8'h01);
    pulse(9'h010);
    wr(OFF_FEATURE, 8'h04);
    idle(3);
    chk(8'(resets), 8'h01);
    sys_state <= '0;
    for (n = 0; n < 16; n++) rd(n[3:0], rexp[n]);
    finish_test();
  end
endmodule
